/* ceru_core.sv */
/*
 * Exception sequencing and reset behaviour of the CPU core: trap entry,
 * illegal-opcode and debug trap entry, the two return instructions,
 * maskable and non-maskable acceptance gating, save registers and the
 * start address, with software access over an AHB-Lite slave port.
 * Assumes the pipeline presents at most one executing instruction per
 * cycle, holds it for one cycle only, and flushes on every redirect.
 */
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`default_nettype none
`include "ceru_consts.svh"

// Function
// RULE1 - Trap always raises a software exception
// RULE2 - Trap saves pc and status into irq pair
// RULE3 - Trap writes code into low cause half
// RULE4 - Trap sets exception and disable flags
// RULE5 - Trap jumps to 40h or 50h by group
// RULE6 - Opcode 3fh, sub 7h..fh, bit16 zero is illegal
// RULE7 - Illegal or debug trap saves into debug pair
// RULE8 - Illegal or debug trap sets busy, exception, disable flags
// RULE9 - Illegal or debug trap sets debug mode
// RULE10 - Illegal and debug traps jump to 60h
// RULE11 - Illegal trap saves offending address plus four
// RULE12 - Break instruction or function trap raises debug trap
// RULE13 - Debug trap support is a build option
// RULE14 - Return uses nmi pair if exception 0, busy 1
// RULE15 - Software sets flags just before the return
// RULE16 - Third nmi accepted while busy
// RULE17 - Debug return reloads debug pair
// RULE18 - Debug return clears debug mode
// RULE19 - Low reset holds core at reset values
// RULE20 - First fetch after reset at zero
// RULE21 - Reset status word is 20h
// RULE22 - Reset debug interface register is 40h
// RULE23 - Maskable requests wait while busy or disabled
// RULE24 - Software exception code is 004nh or 005nh
module ceru_core #(
    parameter bit DEBUG_TRAP_EN = 1'b1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output var logic hreadyout,
    output var logic [31:0] hrdata,
    output var logic hresp,
    input wire ceru_pkg::ceru_exec_t exec_req,
    input wire logic [31:0] resume_pc,
    input wire logic dbg_func_trap,
    input wire logic irq_req,
    input wire logic [15:0] irq_code,
    input wire logic [2:0] nmi_req,
    output var ceru_pkg::ceru_redirect_t redirect,
    output var logic irq_ack,
    output var logic [2:0] nmi_ack,
    output var logic illegal_seen,
    output var logic [31:0] status_word,
    output var logic [31:0] dbg_if_reg
);

    // --------------------
    // Helpers
    // --------------------

    // Illegal opcode pattern
    function automatic logic is_illegal(input logic [31:0] ins);
        is_illegal = (ins[10:5] == `CERU_ILL_OPCODE) &&
                     (ins[26:23] >= `CERU_ILL_SUB_MIN) && !ins[16]; // see RULE6
    endfunction : is_illegal

    // 0 for a mapped aligned word, or 1 in miss for anything else
    function automatic logic reg_miss(input logic [31:0] a);
        reg_miss = (a[31:8] != 24'h00_0000) || (a[1:0] != 2'b00) ||
                   (a[7:0] > `CERU_OFS_FETCH_PC);
    endfunction : reg_miss

    // --------------------
    // State
    // --------------------
    ceru_pkg::ceru_state_t state;
    logic [31:0] cause_reg;
    logic [31:0] irq_return_pc;
    logic [31:0] irq_return_status;
    logic [31:0] nmi_return_pc;
    logic [31:0] nmi_return_status;
    logic [31:0] dbg_return_pc;
    logic [31:0] dbg_return_status;
    logic [31:0] fetch_pc;
    logic bus_pend;
    logic bus_wr;
    logic [7:0] bus_addr;
    logic bus_miss;

    ceru_pkg::ceru_event_t ev;
    logic [31:0] ev_save_pc;
    logic [31:0] ev_target;
    logic [2:0] nmi_take;
    logic [15:0] nmi_code;
    logic ev_illegal;
    logic nmi_busy;
    logic irq_off;
    logic bus_wr_now;

    assign nmi_busy = status_word[`CERU_NP_BIT];
    assign irq_off = status_word[`CERU_NP_BIT] || status_word[`CERU_ID_BIT];
    assign bus_wr_now = bus_pend && bus_wr && !bus_miss;

    // --------------------
    // Event selection
    // --------------------

    // Non-maskable pick: lowest index first; the third bypasses busy
    always_comb begin
        nmi_take = 3'b000;
        nmi_code = 16'h0000;
        if (nmi_req[0] && !nmi_busy) begin
            nmi_take = 3'b001;
            nmi_code = 16'h0010;
        end else if (nmi_req[1] && !nmi_busy) begin
            nmi_take = 3'b010;
            nmi_code = 16'h0020;
        end else if (nmi_req[2]) begin
            nmi_take = 3'b100; // see RULE16
            nmi_code = 16'h0030;
        end
    end

    // Synchronous exceptions beat asynchronous requests
    always_comb begin
        ev = ceru_pkg::CERU_EV_NONE;
        ev_save_pc = resume_pc;
        ev_target = fetch_pc;
        ev_illegal = 1'b0;
        if (state != ceru_pkg::CERU_RUN) begin
            ev = ceru_pkg::CERU_EV_NONE;
        end else if (exec_req.valid) begin
            ev_save_pc = exec_req.next_pc;
            case (exec_req.op)
                ceru_pkg::CERU_OP_TRAP: begin
                    ev = ceru_pkg::CERU_EV_SWX; // see RULE1
                    ev_target = exec_req.trap_vec[4] ?
                                `CERU_VEC_TRAP1 : `CERU_VEC_TRAP0; // see RULE5
                end
                ceru_pkg::CERU_OP_DBREAK: begin
                    if (DEBUG_TRAP_EN) begin // see RULE13
                        ev = ceru_pkg::CERU_EV_DBG; // see RULE12
                        ev_target = `CERU_VEC_DEBUG;
                    end
                end
                ceru_pkg::CERU_OP_IRET: begin
                    ev = ceru_pkg::CERU_EV_IRET;
                    // Flags set by software just before the return steer the pick
                    if (!status_word[`CERU_EP_BIT] && status_word[`CERU_NP_BIT]) begin
                        ev_target = nmi_return_pc; // see RULE14, RULE15
                    end else begin
                        ev_target = irq_return_pc; // see RULE14
                    end
                end
                ceru_pkg::CERU_OP_DRET: begin
                    ev = ceru_pkg::CERU_EV_DRET;
                    ev_target = dbg_return_pc; // see RULE17
                end
                default: begin
                    if (is_illegal(exec_req.instr)) begin
                        ev = ceru_pkg::CERU_EV_DBG;
                        ev_illegal = 1'b1;
                        ev_target = `CERU_VEC_DEBUG; // see RULE10
                        ev_save_pc = exec_req.pc + `CERU_ILL_PC_STEP; // see RULE11
                    end
                end
            endcase
        end else if (dbg_func_trap && DEBUG_TRAP_EN) begin
            ev = ceru_pkg::CERU_EV_DBG; // see RULE12, RULE13
            ev_target = `CERU_VEC_DEBUG;
        end else if (nmi_take != 3'b000) begin
            ev = ceru_pkg::CERU_EV_NMI;
            ev_target = {16'h0000, nmi_code};
        end else if (irq_req && !irq_off) begin
            ev = ceru_pkg::CERU_EV_IRQ; // see RULE23
            ev_target = {16'h0000, irq_code};
        end
    end

    // --------------------
    // Boot sequencing
    // --------------------

    // One boot cycle after release lets the redirect to zero go out first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ceru_pkg::CERU_BOOT; // see RULE19
        end else begin
            case (state)
                ceru_pkg::CERU_BOOT: state <= ceru_pkg::CERU_RUN;
                ceru_pkg::CERU_RUN: state <= ceru_pkg::CERU_RUN;
                default: state <= ceru_pkg::CERU_BOOT;
            endcase
        end
    end

    // --------------------
    // Fetch redirect and acknowledges
    // --------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            redirect <= '0;
            fetch_pc <= `CERU_BOOT_PC;
        end else if (state == ceru_pkg::CERU_BOOT) begin
            redirect.valid <= 1'b1;
            redirect.pc <= `CERU_BOOT_PC; // see RULE20
            fetch_pc <= `CERU_BOOT_PC;
        end else begin
            redirect.valid <= (ev != ceru_pkg::CERU_EV_NONE);
            if (ev != ceru_pkg::CERU_EV_NONE) begin
                redirect.pc <= ev_target;
                fetch_pc <= ev_target;
            end
        end
    end

    // Acknowledge pulses let the request sources drop their lines
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_ack <= 1'b0;
            nmi_ack <= 3'b000;
            illegal_seen <= 1'b0;
        end else begin
            irq_ack <= (ev == ceru_pkg::CERU_EV_IRQ);
            nmi_ack <= (ev == ceru_pkg::CERU_EV_NMI) ? nmi_take : 3'b000;
            illegal_seen <= ev_illegal;
        end
    end

    // --------------------
    // Status word
    // --------------------

    // Hardware events win over a bus write in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_word <= `CERU_STATUS_RST; // see RULE21
        end else begin
            case (ev)
                ceru_pkg::CERU_EV_SWX: begin
                    status_word[`CERU_EP_BIT] <= 1'b1; // see RULE4
                    status_word[`CERU_ID_BIT] <= 1'b1;
                end
                ceru_pkg::CERU_EV_DBG: begin
                    status_word[`CERU_NP_BIT] <= 1'b1; // see RULE8
                    status_word[`CERU_EP_BIT] <= 1'b1;
                    status_word[`CERU_ID_BIT] <= 1'b1;
                end
                ceru_pkg::CERU_EV_NMI: begin
                    status_word[`CERU_NP_BIT] <= 1'b1;
                    status_word[`CERU_EP_BIT] <= 1'b0;
                    status_word[`CERU_ID_BIT] <= 1'b1;
                end
                ceru_pkg::CERU_EV_IRQ: begin
                    status_word[`CERU_EP_BIT] <= 1'b0;
                    status_word[`CERU_ID_BIT] <= 1'b1;
                end
                ceru_pkg::CERU_EV_IRET: begin
                    if (!status_word[`CERU_EP_BIT] && status_word[`CERU_NP_BIT]) begin
                        status_word <= nmi_return_status; // see RULE14
                    end else begin
                        status_word <= irq_return_status;
                    end
                end
                ceru_pkg::CERU_EV_DRET: status_word <= dbg_return_status; // see RULE17
                default: begin
                    if (bus_wr_now && bus_addr == `CERU_OFS_STATUS) begin
                        status_word <= hwdata & `CERU_SAVE_ST_MASK;
                    end
                end
            endcase
        end
    end

    // --------------------
    // Debug interface register
    // --------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dbg_if_reg <= `CERU_DBG_IF_RST; // see RULE22
        end else if (ev == ceru_pkg::CERU_EV_DBG) begin
            dbg_if_reg[`CERU_DM_BIT] <= 1'b1; // see RULE9
        end else if (ev == ceru_pkg::CERU_EV_DRET) begin
            dbg_if_reg[`CERU_DM_BIT] <= 1'b0; // see RULE18
        end else if (bus_wr_now && bus_addr == `CERU_OFS_DBG_IF) begin
            dbg_if_reg <= hwdata;
        end
    end

    // --------------------
    // Cause register
    // --------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cause_reg <= `CERU_CAUSE_RST;
        end else if (ev == ceru_pkg::CERU_EV_SWX) begin
            // Group and number fold into 004n or 005n
            cause_reg[15:0] <= `CERU_CODE_TRAP_BASE +
                               {11'h000, exec_req.trap_vec}; // see RULE3, RULE24
        end else if (ev == ceru_pkg::CERU_EV_IRQ) begin
            cause_reg[15:0] <= irq_code;
        end else if (ev == ceru_pkg::CERU_EV_NMI) begin
            cause_reg[31:16] <= nmi_code;
        end else if (bus_wr_now && bus_addr == `CERU_OFS_CAUSE) begin
            cause_reg <= hwdata;
        end
    end

    // --------------------
    // Save registers
    // --------------------

    // Maskable and software exception saves share one pair
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_return_pc <= 32'h0000_0000;
            irq_return_status <= 32'h0000_0000;
        end else if (ev == ceru_pkg::CERU_EV_SWX || ev == ceru_pkg::CERU_EV_IRQ) begin
            irq_return_pc <= ev_save_pc; // see RULE2
            irq_return_status <= status_word & `CERU_SAVE_ST_MASK;
        end else if (bus_wr_now && bus_addr == `CERU_OFS_IRQ_PC) begin
            irq_return_pc <= hwdata;
        end else if (bus_wr_now && bus_addr == `CERU_OFS_IRQ_STATUS) begin
            irq_return_status <= hwdata & `CERU_SAVE_ST_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nmi_return_pc <= 32'h0000_0000;
            nmi_return_status <= 32'h0000_0000;
        end else if (ev == ceru_pkg::CERU_EV_NMI) begin
            nmi_return_pc <= ev_save_pc;
            nmi_return_status <= status_word & `CERU_SAVE_ST_MASK;
        end else if (bus_wr_now && bus_addr == `CERU_OFS_NMI_PC) begin
            nmi_return_pc <= hwdata;
        end else if (bus_wr_now && bus_addr == `CERU_OFS_NMI_STATUS) begin
            nmi_return_status <= hwdata & `CERU_SAVE_ST_MASK;
        end
    end

    // Only one debug pair: a nested debug trap overwrites it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dbg_return_pc <= 32'h0000_0000;
            dbg_return_status <= 32'h0000_0000;
        end else if (ev == ceru_pkg::CERU_EV_DBG) begin
            dbg_return_pc <= ev_save_pc; // see RULE7
            dbg_return_status <= status_word & `CERU_SAVE_ST_MASK;
        end else if (bus_wr_now && bus_addr == `CERU_OFS_DBG_PC) begin
            dbg_return_pc <= hwdata;
        end else if (bus_wr_now && bus_addr == `CERU_OFS_DBG_STATUS) begin
            dbg_return_status <= hwdata & `CERU_SAVE_ST_MASK;
        end
    end

    // --------------------
    // AHB-Lite slave
    // --------------------

    // Address phase capture; one wait state keeps hrdata a flop output
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_pend <= 1'b0;
            bus_wr <= 1'b0;
            bus_addr <= 8'h00;
            bus_miss <= 1'b0;
        end else if (hsel && htrans[1] && hready) begin
            bus_pend <= 1'b1;
            bus_wr <= hwrite;
            bus_addr <= haddr[7:0];
            bus_miss <= reg_miss(haddr) || (hsize != 3'h2);
        end else begin
            bus_pend <= 1'b0;
        end
    end

    // Response: wait one cycle, then finish with data; always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (hsel && htrans[1] && hready) begin
                hreadyout <= 1'b0;
            end else begin
                hreadyout <= 1'b1;
            end
            if (bus_pend && !bus_wr && !bus_miss) begin
                case (bus_addr)
                    `CERU_OFS_STATUS: hrdata <= status_word;
                    `CERU_OFS_CAUSE: hrdata <= cause_reg;
                    `CERU_OFS_IRQ_PC: hrdata <= irq_return_pc;
                    `CERU_OFS_IRQ_STATUS: hrdata <= irq_return_status;
                    `CERU_OFS_NMI_PC: hrdata <= nmi_return_pc;
                    `CERU_OFS_NMI_STATUS: hrdata <= nmi_return_status;
                    `CERU_OFS_DBG_PC: hrdata <= dbg_return_pc;
                    `CERU_OFS_DBG_STATUS: hrdata <= dbg_return_status;
                    `CERU_OFS_DBG_IF: hrdata <= dbg_if_reg;
                    `CERU_OFS_FETCH_PC: hrdata <= fetch_pc;
                    default: hrdata <= 32'h0000_0000;
                endcase
            end else if (bus_pend) begin
                hrdata <= 32'h0000_0000; // Unmapped and writes read as zero
            end
        end
    end

endmodule : ceru_core

`default_nettype wire

/* ceru_consts.svh */
/*
 * Constants of the exception and reset unit: register offsets, field
 * positions, reset values, handler vectors and exception codes.
 * Assumes inclusion by bare name from the core, the checker and the bench.
 */
`ifndef CERU_CONSTS_SVH
`define CERU_CONSTS_SVH

// --------------------
// Register offsets (byte addresses, one aligned word each)
// --------------------
`define CERU_OFS_STATUS      8'h00
`define CERU_OFS_CAUSE       8'h04
`define CERU_OFS_IRQ_PC      8'h08
`define CERU_OFS_IRQ_STATUS  8'h0c
`define CERU_OFS_NMI_PC      8'h10
`define CERU_OFS_NMI_STATUS  8'h14
`define CERU_OFS_DBG_PC      8'h18
`define CERU_OFS_DBG_STATUS  8'h1c
`define CERU_OFS_DBG_IF      8'h20
`define CERU_OFS_FETCH_PC    8'h24

// --------------------
// Field positions
// --------------------
`define CERU_ID_BIT          5
`define CERU_EP_BIT          6
`define CERU_NP_BIT          7
`define CERU_DM_BIT          0

// --------------------
// Reset values and masks
// --------------------
`define CERU_STATUS_RST      32'h0000_0020
`define CERU_DBG_IF_RST      32'h0000_0040
`define CERU_CAUSE_RST       32'h0000_0000
`define CERU_BOOT_PC         32'h0000_0000
`define CERU_SAVE_ST_MASK    32'h0000_0fff

// --------------------
// Handler vectors and exception codes
// --------------------
`define CERU_VEC_TRAP0       32'h0000_0040
`define CERU_VEC_TRAP1       32'h0000_0050
`define CERU_VEC_DEBUG       32'h0000_0060
`define CERU_CODE_TRAP_BASE  16'h0040
`define CERU_ILL_OPCODE      6'h3f
`define CERU_ILL_SUB_MIN     4'h7
`define CERU_ILL_PC_STEP     32'h0000_0004

`endif

/* ceru_pkg.sv */
/*
 * Types of the exception and reset unit: the execute-stage request
 * carrier, the fetch redirect carrier, states and event kinds.
 * Assumes ceru_consts.svh is on the include path.
 */
`default_nettype none

package ceru_pkg;

    // Instruction class handed over by the decoder at execute
    typedef enum logic [2:0] {
        CERU_OP_OTHER = 3'h0,
        CERU_OP_TRAP = 3'h1,
        CERU_OP_DBREAK = 3'h2,
        CERU_OP_IRET = 3'h3,
        CERU_OP_DRET = 3'h4
    } ceru_op_t;

    typedef struct packed {
        logic valid;
        ceru_op_t op;
        logic [4:0] trap_vec;
        logic [31:0] instr;
        logic [31:0] pc;
        logic [31:0] next_pc;
    } ceru_exec_t;

    typedef struct packed {
        logic valid;
        logic [31:0] pc;
    } ceru_redirect_t;

    typedef enum logic [1:0] {
        CERU_BOOT = 2'b01,
        CERU_RUN = 2'b10
    } ceru_state_t;

    typedef enum logic [2:0] {
        CERU_EV_NONE = 3'h0,
        CERU_EV_SWX = 3'h1,
        CERU_EV_DBG = 3'h2,
        CERU_EV_IRET = 3'h3,
        CERU_EV_DRET = 3'h4,
        CERU_EV_NMI = 3'h5,
        CERU_EV_IRQ = 3'h6
    } ceru_event_t;

endpackage : ceru_pkg

`default_nettype wire

/* ceru_core_properties.sv */
/* Port checker for ceru_core, bound below.
   Assumes ceru_pkg is compiled and ceru_consts.svh is on the path. */
`default_nettype none
`include "ceru_consts.svh"
module ceru_core_properties (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire ceru_pkg::ceru_exec_t exec_req,
    input wire logic irq_req,
    input wire ceru_pkg::ceru_redirect_t redirect,
    input wire logic irq_ack,
    input wire logic illegal_seen,
    input wire logic [31:0] status_word,
    input wire logic [31:0] dbg_if_reg
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic ill, trap, dbrk, dret;
    // Decode kept apart so each property reads as cause and effect
    assign ill = exec_req.valid && exec_req.op == ceru_pkg::CERU_OP_OTHER && exec_req.instr[10:5] == `CERU_ILL_OPCODE
        && exec_req.instr[26:23] >= `CERU_ILL_SUB_MIN && !exec_req.instr[16];
    assign trap = exec_req.valid && exec_req.op == ceru_pkg::CERU_OP_TRAP;
    assign dbrk = exec_req.valid && exec_req.op == ceru_pkg::CERU_OP_DBREAK;
    assign dret = exec_req.valid && exec_req.op == ceru_pkg::CERU_OP_DRET;
    // Wait state of one cycle, then ready again
    sequence s_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    chk_boot_fetch: assert property (!$past(hresetn) |=> redirect.valid && redirect.pc == `CERU_BOOT_PC)
        else $error("boot fetch address wrong");
    chk_reset_vals: assert property (!$past(hresetn) |-> status_word == `CERU_STATUS_RST && dbg_if_reg == `CERU_DBG_IF_RST)
        else $error("reset values wrong");
    chk_trap_vector: assert property (trap |=> redirect.valid
        && redirect.pc == ($past(exec_req.trap_vec[4]) ? `CERU_VEC_TRAP1 : `CERU_VEC_TRAP0)) else $error("trap vector wrong");
    chk_trap_flags: assert property (trap |=> status_word[6:5] == 2'b11)
        else $error("trap flags wrong");
    chk_illegal_entry: assert property (ill |=> illegal_seen && redirect.pc == `CERU_VEC_DEBUG)
        else $error("illegal entry wrong");
    chk_debug_flags: assert property (ill || dbrk |=> status_word[7:5] == 3'h7 && dbg_if_reg[0])
        else $error("debug entry flags wrong");
    chk_dret_clear: assert property (dret |=> redirect.valid && !dbg_if_reg[0])
        else $error("debug return flag wrong");
    chk_irq_masked: assert property (irq_req && (status_word[7] || status_word[5]) |=> !irq_ack)
        else $error("masked request taken");
    chk_bus_wait: assert property (hsel && htrans[1] && hready |=> s_wait)
        else $error("bus wait state wrong");
endmodule : ceru_core_properties
bind ceru_core ceru_core_properties u_props (.*);
`default_nettype wire

/* ceru_pipe_model.sv */
/* Fetch and execute pipeline seen from the exception unit.
   Assumes the bench pulses issue for one cycle per instruction. */
`default_nettype none
module ceru_pipe_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic issue,
    input wire ceru_pkg::ceru_op_t op,
    input wire logic [4:0] vec,
    input wire logic [31:0] instr,
    input wire ceru_pkg::ceru_redirect_t redirect,
    output var ceru_pkg::ceru_exec_t exec_req,
    output var logic [31:0] fetch_pc
);
    // A redirect flushes and wins over sequential fetch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) fetch_pc <= 32'h0;
        else if (redirect.valid) fetch_pc <= redirect.pc;
        else if (issue) fetch_pc <= fetch_pc + 32'h4;
    end
    // Word-sized instructions only, so next pc is always pc plus four
    assign exec_req = '{issue, op, vec, instr, fetch_pc, fetch_pc + 32'h4};
endmodule : ceru_pipe_model
`default_nettype wire

/* ceru_core_test.sv */
/* Self-checking bench for ceru_core with a pipeline model.
   Assumes the checker file and the model are compiled before it. */
`default_nettype none
`include "ceru_consts.svh"
module ceru_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, irq_req = 1'b0, issue = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, instr = 32'h0, seed = 32'hd897, rd, t, pc0, pc1, m_st;
    logic [31:0] last_pc = 32'h1, hrdata, status_word, dbg_if_reg, resume_pc;
    logic hreadyout, hresp, irq_ack, illegal_seen, dbg_func_trap = 1'b0;
    logic [2:0] nmi_ack, nmi_req = 3'h0, nack = 3'h0;
    logic [4:0] vec = 5'h0;
    logic [15:0] irq_code = 16'h0;
    ceru_pkg::ceru_op_t op = ceru_pkg::CERU_OP_OTHER;
    ceru_pkg::ceru_exec_t exec_req;
    ceru_pkg::ceru_redirect_t redirect;
    int num_errors = 0, compares = 0, acks = 0, ills = 0;
    ceru_core DUT (.*, .hready(hreadyout));
    ceru_pipe_model u_pipe (.*, .fetch_pc(resume_pc));
    initial begin
        forever #5 hclk = ~hclk;
    end
    // Last fetch target and acknowledge count, the model's view of the core
    always @(posedge hclk) begin
        if (redirect.valid === 1'b1) last_pc <= redirect.pc;
        if (irq_ack === 1'b1) acks <= acks + 1;
        if (illegal_seen === 1'b1) ills <= ills + 1;
        nack <= nack | nmi_ack;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic end_of_test();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Single word transfer; waits on ready in both phases, bounded
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 20);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 20);
        rd = hrdata;
        hsel <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            end_of_test();
        end
    endtask : bus
    task automatic run(ceru_pkg::ceru_op_t o, logic [4:0] v, logic [31:0] i);
        issue <= 1'b1;
        op <= o;
        vec <= v;
        instr <= i;
        @(posedge hclk);
        issue <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask : run
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        chk("status", 32'h20, status_word);
        chk("dbg_if", 32'h40, dbg_if_reg);
        chk("boot pc", 32'h0, last_pc);
        t = rnd();
        irq_code <= {8'h0, t[7:2], 2'b00};
        irq_req <= 1'b1;
        pc1 = resume_pc + 32'h4;
        run(ceru_pkg::CERU_OP_TRAP, t[12:8], t);
        chk("trap pc", t[12] ? 32'h50 : 32'h40, last_pc);
        chk("trap status", 32'h60, status_word);
        bus(1'b0, `CERU_OFS_CAUSE, 32'h0);
        chk("cause", {27'h2, t[12:8]}, rd);
        bus(1'b0, `CERU_OFS_IRQ_PC, 32'h0);
        chk("irq save pc", pc1, rd);
        // Illegal opcode first, then the debug break instruction
        for (int k = 0; k < 2; k++) begin
            t = rnd() | 32'h0380_07e0;
            t[16] = 1'b0;
            pc0 = resume_pc + 32'h4;
            m_st = status_word;
            run(k ? ceru_pkg::CERU_OP_DBREAK : ceru_pkg::CERU_OP_OTHER, 5'h0, t);
            chk("dbg vector", 32'h60, last_pc);
            chk("dbg status", m_st | 32'he0, status_word);
            chk("dbg mode", 32'h41, dbg_if_reg);
            bus(1'b0, `CERU_OFS_DBG_PC, 32'h0);
            chk("dbg save pc", pc0, rd);
            run(ceru_pkg::CERU_OP_DRET, 5'h0, 32'h0);
            chk("dret pc", pc0, last_pc);
            chk("dret status", m_st, status_word);
            chk("dret mode", 32'h40, dbg_if_reg);
        end
        chk("ill pulses", 32'h1, 32'(ills));
        bus(1'b1, `CERU_OFS_STATUS, 32'h60);
        run(ceru_pkg::CERU_OP_IRET, 5'h0, 32'h0);
        chk("iret pc", pc1, last_pc);
        chk("iret status", 32'h20, status_word);
        chk("masked acks", 32'h0, 32'(acks));
        bus(1'b1, `CERU_OFS_STATUS, 32'h0);
        repeat (4) @(posedge hclk);
        chk("irq acks", 32'h1, 32'(acks));
        chk("irq pc", {16'h0, irq_code}, last_pc);
        irq_req <= 1'b0;
        dbg_func_trap <= 1'b1;
        @(posedge hclk);
        dbg_func_trap <= 1'b0;
        nmi_req <= 3'h5;
        repeat (3) @(posedge hclk);
        nmi_req <= 3'h0;
        chk("func trap", 32'h41, dbg_if_reg);
        chk("third_nonmaskable_input pc ack", 32'h34, last_pc | nack);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd | 32'(hresp));
        end_of_test();
    end
endmodule : ceru_core_test
`default_nettype wire
